/* pkg/muart_consts.svh */
`ifndef MUART_CONSTS_SVH
`define MUART_CONSTS_SVH

// Register indices; the byte address is four times the index
`define MUART_IDX_DATA 12'h000
`define MUART_IDX_CMD 12'h001
`define MUART_IDX_ISTAT 12'h002
`define MUART_IDX_ICLR 12'h003
`define MUART_IDX_IEN 12'h004
`define MUART_IDX_CFG 12'h0F0

// Command codes and fixed data values
`define MUART_CMD_RESET 8'hFF
`define MUART_CMD_UART 8'h3F
`define MUART_ACK_CODE 8'hFE
`define MUART_STAT_LOW 6'h3F

// Field positions
`define MUART_RXS_BIT 7
`define MUART_TXS_BIT 6
`define MUART_TRIG_MSB 2
`define MUART_TRIG_LSB 1
`define MUART_INT_LEVEL 0
`define MUART_INT_ACK 1
`define MUART_INT_OVR 2

// Reset values
`define MUART_CFG_RESET 8'h00
`define MUART_IEN_RESET 3'h0

// Receive trigger levels in bytes, by select code
`define MUART_TRIG0 1
`define MUART_TRIG1 4
`define MUART_TRIG2 8
`define MUART_TRIG3 14

// Timing: clock rate, serial rate in baud, cycles per bit
`define MUART_CLK_HZ 20000000
`define MUART_BAUD 31250
`define MUART_BIT_CYCLES (`MUART_CLK_HZ / `MUART_BAUD)
`define MUART_FIFO_DEPTH 16

`endif

/* pkg/muart_pkg.sv */
package muart_pkg;

    // Port operating mode
    typedef enum logic {intel_mode, uart_mode} muart_mode_t;

    // Serial frame phase, shared by receiver and transmitter
    typedef enum logic [1:0] {ser_idle, ser_start, ser_data, ser_stop} muart_ser_t;

endpackage

/* hdl/muart_fifo.sv */
`timescale 1ns/10ps
module muart_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic flush,
    // Fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    // Drain side
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    // Occupancy
    output logic [$clog2(DEPTH):0] count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic do_push;
    logic do_pop;

    // Refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    // Accepted moves
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign pop_data = mem[rd_ptr_reg];
    assign count = count_reg;
    assign full = count_reg == (AW+1)'(DEPTH);
    assign empty = count_reg == '0;

    // Storage array
    always_ff @(posedge pclk)
    begin
        if (do_push)
            mem[wr_ptr_reg] <= push_data;
    end

    // Pointers and occupancy, flush first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            if (do_pop)
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            if (do_push && !do_pop)
                count_reg <= count_reg + (AW+1)'(1);
            else if (do_pop && !do_push)
                count_reg <= count_reg - (AW+1)'(1);
        end
    end
endmodule

/* hdl/muart_port.sv */
// What this block does
// - Host read of data port in UART mode pops the oldest receive byte.
// - In UART mode each byte received on the serial input is pushed into the receive FIFO; a byte arriving while it is full is dropped and sets the overrun flag.
// - Receive empty flag, status bit 7, follows receive FIFO occupancy in UART mode and reads 0 in intelligent mode.
// - Receive interrupt only while occupancy is at or above trigger level.
// - Receive interrupt drops as soon as occupancy falls below trigger.
// - Trigger level chosen by bits 2-1 of the special config register.
// - Host write to data port in UART mode pushes into transmit FIFO.
// - Transmitter sends transmit FIFO bytes in order on the serial output.
// - Transmit full flag, status bit 6, follows transmit FIFO occupancy.
// - Command FFh empties both FIFOs and restores intelligent mode; other registers and a frame in flight are kept.
// - In UART mode every other command code is a no-operation.
// - Frames are 1 start, 8 data, 1 stop bit at 31.25 kbaud.
// - Each FIFO holds sixteen bytes.
// - Status reads 0/1 receive and transmit flags, low six bits 3Fh.
// - Reset gives intelligent mode; 3Fh enters UART mode and loads FEh.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`include "muart_consts.svh"
`timescale 1ns/10ps
module muart_port
    import muart_pkg::*;
#(
    parameter int BIT_CYCLES = `MUART_BIT_CYCLES,
    parameter int DEPTH = `MUART_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial lines
    input wire logic music_serial_in,
    output logic music_serial_out,
    // Interrupt
    output logic irq
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int BCW = $clog2(BIT_CYCLES + 1);

    // Refuse settings the logic cannot serve
    if (BIT_CYCLES < 4 || DEPTH < `MUART_TRIG3)
    begin : g_bad_param
        $error("bit time or fifo depth too small");
    end

    // Byte address of a register index
    function automatic logic [11:0] byte_addr(input logic [11:0] idx);
        return {idx[9:0], 2'h0};
    endfunction

    // Trigger level in bytes for a select code
    function automatic logic [CW-1:0] trig_count(input logic [1:0] sel);
        unique case (sel)
            2'h0: return CW'(`MUART_TRIG0);
            2'h1: return CW'(`MUART_TRIG1);
            2'h2: return CW'(`MUART_TRIG2);
            2'h3: return CW'(`MUART_TRIG3);
        endcase
    endfunction

    muart_mode_t mode_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic rd_pop_ok_reg;
    logic [7:0] cfg_reg;
    logic [2:0] ien_reg;
    logic rx_level_reg;
    logic rx_level_next;
    logic ack_int_reg;
    logic ack_int_next;
    logic ovr_int_reg;
    logic ovr_int_next;
    logic irq_reg;
    logic rx_buffer_empty_flag_reg;
    logic tx_buffer_full_flag_reg;
    logic sin_meta_reg;
    logic sin_reg;
    muart_ser_t rx_state;
    logic [BCW-1:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_done_reg;
    muart_ser_t tx_state;
    logic [BCW-1:0] tx_cnt;
    logic [2:0] tx_bits;
    logic [7:0] tx_shift;
    logic sout_reg;
    logic setup;
    logic access;
    logic sel_data;
    logic sel_cmd;
    logic sel_istat;
    logic sel_iclr;
    logic sel_ien;
    logic sel_cfg;
    logic wr_data;
    logic wr_cmd;
    logic rd_data;
    logic flush;
    logic ack_push;
    logic rx_push;
    logic rx_pop;
    logic [7:0] rx_head;
    logic [CW-1:0] rx_count;
    logic rx_full;
    logic rx_empty;
    logic tx_push;
    logic tx_pop;
    logic [7:0] tx_head;
    logic [CW-1:0] tx_count;
    logic tx_full;
    logic tx_empty;
    logic [1:0] trig_sel;
    logic [31:0] rd_mux;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus phases and address decode
    assign setup = psel && !penable;
    assign access = psel && penable && pready_reg;
    assign sel_data = paddr == byte_addr(`MUART_IDX_DATA);
    assign sel_cmd = paddr == byte_addr(`MUART_IDX_CMD);
    assign sel_istat = paddr == byte_addr(`MUART_IDX_ISTAT);
    assign sel_iclr = paddr == byte_addr(`MUART_IDX_ICLR);
    assign sel_ien = paddr == byte_addr(`MUART_IDX_IEN);
    assign sel_cfg = paddr == byte_addr(`MUART_IDX_CFG);
    assign wr_data = access && pwrite && sel_data;
    assign wr_cmd = access && pwrite && sel_cmd;
    assign rd_data = access && !pwrite && sel_data;
    assign trig_sel = cfg_reg[`MUART_TRIG_MSB:`MUART_TRIG_LSB];

    // Read data selection
    always_comb
    begin
        rd_mux = '0;
        if (sel_data)
            rd_mux[7:0] = (mode_reg == intel_mode) ? `MUART_ACK_CODE
                : (rx_empty ? 8'h00 : rx_head);
        else if (sel_cmd)
            rd_mux[7:0] = {rx_buffer_empty_flag_reg, tx_buffer_full_flag_reg,
                `MUART_STAT_LOW};
        else if (sel_istat)
            rd_mux[2:0] = {ovr_int_reg, ack_int_reg, rx_level_reg};
        else if (sel_ien)
            rd_mux[2:0] = ien_reg;
        else if (sel_cfg)
            rd_mux[7:0] = cfg_reg;
    end

    // Bus answer: one setup and one access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= '0;
            pslverr_reg <= '0;
            prdata_reg <= '0;
            rd_pop_ok_reg <= '0;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !(sel_data || sel_cmd || sel_istat
                || sel_iclr || sel_ien || sel_cfg);
            if (setup && !pwrite)
                prdata_reg <= rd_mux;
            rd_pop_ok_reg <= setup && !pwrite && sel_data
                && mode_reg == uart_mode && !rx_empty;
        end
    end

    // Host configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg <= `MUART_CFG_RESET;
            ien_reg <= `MUART_IEN_RESET;
        end
        else
        begin
            if (access && pwrite && sel_cfg)
                cfg_reg <= pwdata[7:0];
            if (access && pwrite && sel_ien)
                ien_reg <= pwdata[2:0];
        end
    end
    cfg_trig_a: assert property (
        (access && pwrite && sel_cfg) |=> trig_sel == $past(pwdata[2:1]))
        else $error("trigger select not taken");

    assign flush = wr_cmd && pwdata[7:0] == `MUART_CMD_RESET;
    assign ack_push = wr_cmd && pwdata[7:0] == `MUART_CMD_UART
        && mode_reg == intel_mode;

    // Mode control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= intel_mode;
        else if (flush)
            mode_reg <= intel_mode;
        else if (ack_push)
            mode_reg <= uart_mode;
    end
    cmd_reset_a: assert property (
        flush |=> mode_reg == intel_mode && rx_empty && tx_empty)
        else $error("reset command did not restore initial state");
    cmd_noop_a: assert property (
        (wr_cmd && mode_reg == uart_mode && !flush) |=> mode_reg == uart_mode)
        else $error("no-op command changed mode");
    ack_entry_a: assert property (
        ack_push |=> mode_reg == uart_mode && ack_int_reg
        && rx_count == CW'(1) && rx_head == `MUART_ACK_CODE)
        else $error("uart entry did not load acknowledge");
    intel_read_a: assert property (
        (rd_data && mode_reg == intel_mode) |-> prdata[7:0] == `MUART_ACK_CODE)
        else $error("intelligent mode read not acknowledge code");

    // FIFO traffic
    // store received bytes
    assign rx_push = (rx_done_reg && mode_reg == uart_mode) || ack_push;
    assign rx_pop = rd_data && rd_pop_ok_reg;
    assign tx_push = wr_data && mode_reg == uart_mode;
    assign tx_pop = tx_state == ser_idle && !tx_empty;

    muart_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush),
        .push(rx_push),
        .push_data(ack_push ? `MUART_ACK_CODE : rx_shift),
        .pop(rx_pop),
        .pop_data(rx_head),
        .count(rx_count),
        .full(rx_full),
        .empty(rx_empty)
    );

    muart_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush),
        .push(tx_push),
        .push_data(pwdata[7:0]),
        .pop(tx_pop),
        .pop_data(tx_head),
        .count(tx_count),
        .full(tx_full),
        .empty(tx_empty)
    );
    pop_data_a: assert property (
        rx_pop |-> prdata == {24'h0, rx_head} ##1 ($past(rx_push)
        || rx_count + CW'(1) == $past(rx_count)))
        else $error("data read did not pop oldest byte");
    rx_push_a: assert property (
        (rx_push && !rx_full && !rx_pop && !flush)
        |=> rx_count == $past(rx_count) + CW'(1))
        else $error("received byte not stored");
    tx_push_a: assert property (
        (tx_push && !tx_full && !tx_pop) |=> tx_count == $past(tx_count) + CW'(1))
        else $error("written byte not queued");
    fifo_depth_a: assert property (
        rx_count <= DEPTH && tx_count <= DEPTH && (tx_full == (tx_count == DEPTH)))
        else $error("fifo occupancy out of range");

    // Status flags track occupancy every cycle; the receive flag does so only in UART mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_buffer_empty_flag_reg <= '0;
            tx_buffer_full_flag_reg <= '0;
        end
        else
        begin
            rx_buffer_empty_flag_reg <= mode_reg == uart_mode && rx_empty;
            tx_buffer_full_flag_reg <= tx_full;
        end
    end
    rx_flag_a: assert property (
        (mode_reg == uart_mode) |=> rx_buffer_empty_flag_reg == $past(rx_empty))
        else $error("receive flag stale");
    tx_flag_a: assert property (
        1 |=> tx_buffer_full_flag_reg == $past(tx_full))
        else $error("transmit flag stale");
    stat_code_a: assert property (
        (access && !pwrite && sel_cmd) |-> prdata[5:0] == `MUART_STAT_LOW
        && prdata[31:8] == 24'h0)
        else $error("status low bits wrong");

    // Interrupt status: live level, sticky events, set beats clear
    always_comb
    begin
        rx_level_next = mode_reg == uart_mode && rx_count >= trig_count(trig_sel);
        ack_int_next = (ack_int_reg && !(access && pwrite && sel_iclr
            && pwdata[`MUART_INT_ACK])) || ack_push;
        ovr_int_next = (ovr_int_reg && !(access && pwrite && sel_iclr
            && pwdata[`MUART_INT_OVR])) || (rx_done_reg && mode_reg == uart_mode
            && rx_full);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_level_reg <= '0;
            ack_int_reg <= '0;
            ovr_int_reg <= '0;
            irq_reg <= '0;
        end
        else
        begin
            rx_level_reg <= rx_level_next;
            ack_int_reg <= ack_int_next;
            ovr_int_reg <= ovr_int_next;
            irq_reg <= |({ovr_int_next, ack_int_next, rx_level_next} & ien_reg);
        end
    end
    rx_irq_on_a: assert property (
        rx_level_reg |-> $past(rx_count) >= $past(trig_count(trig_sel)))
        else $error("receive interrupt below trigger");
    rx_irq_off_a: assert property (
        (rx_count < trig_count(trig_sel)) |=> !rx_level_reg)
        else $error("receive interrupt not withdrawn");

    // Serial input synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sin_meta_reg <= '1;
            sin_reg <= '1;
        end
        else
        begin
            sin_meta_reg <= music_serial_in;
            sin_reg <= sin_meta_reg;
        end
    end

    // Receiver: mid-bit sampling, stop bit must be high
    // receive frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state <= ser_idle;
            rx_cnt <= '0;
            rx_bits <= '0;
            rx_shift <= '0;
            rx_done_reg <= '0;
        end
        else
        begin
            rx_done_reg <= '0;
            rx_cnt <= rx_cnt + BCW'(1);
            unique case (rx_state)
                ser_idle:
                begin
                    rx_cnt <= '0;
                    if (!sin_reg)
                        rx_state <= ser_start;
                end
                ser_start:
                    if (rx_cnt == BCW'(BIT_CYCLES / 2 - 1))
                    begin
                        rx_cnt <= '0;
                        rx_bits <= '0;
                        rx_state <= sin_reg ? ser_idle : ser_data;
                    end
                ser_data:
                    if (rx_cnt == BCW'(BIT_CYCLES - 1))
                    begin
                        rx_cnt <= '0;
                        rx_shift <= {sin_reg, rx_shift[7:1]};
                        rx_bits <= rx_bits + 3'h1;
                        if (rx_bits == 3'h7)
                            rx_state <= ser_stop;
                    end
                ser_stop:
                    if (rx_cnt == BCW'(BIT_CYCLES - 1))
                    begin
                        rx_done_reg <= sin_reg;
                        rx_state <= ser_idle;
                    end
            endcase
        end
    end

    // Transmitter: start, eight bits LSB first, stop
    // transmit frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state <= ser_idle;
            tx_cnt <= '0;
            tx_bits <= '0;
            tx_shift <= '0;
            sout_reg <= '1;
        end
        else
        begin
            tx_cnt <= tx_cnt + BCW'(1);
            unique case (tx_state)
                ser_idle:
                begin
                    tx_cnt <= '0;
                    if (tx_pop)
                    begin
                        tx_shift <= tx_head;
                        sout_reg <= '0;
                        tx_state <= ser_start;
                    end
                end
                ser_start, ser_data:
                    if (tx_cnt == BCW'(BIT_CYCLES - 1))
                    begin
                        tx_cnt <= '0;
                        if (tx_state == ser_data && tx_bits == 3'h7)
                        begin
                            sout_reg <= '1;
                            tx_state <= ser_stop;
                        end
                        else
                        begin
                            if (tx_state == ser_data)
                                tx_bits <= tx_bits + 3'h1;
                            else
                                tx_bits <= '0;
                            sout_reg <= tx_shift[0];
                            tx_shift <= {1'h0, tx_shift[7:1]};
                            tx_state <= ser_data;
                        end
                    end
                ser_stop:
                    if (tx_cnt == BCW'(BIT_CYCLES - 1))
                        tx_state <= ser_idle;
            endcase
        end
    end
    tx_start_a: assert property (
        tx_pop |=> !music_serial_out && tx_shift == $past(tx_head))
        else $error("transmit did not start with oldest byte");
    frame_stop_a: assert property (
        (tx_state == ser_stop) |-> music_serial_out && tx_cnt < BCW'(BIT_CYCLES))
        else $error("stop bit not high");

    // Main scenarios
    rx_byte_c: cover property (rx_done_reg && mode_reg == uart_mode);
    ack_entry_c: cover property (ack_push);
    tx_frame_c: cover property (tx_state == ser_stop ##1 tx_state == ser_idle);
    irq_rise_c: cover property ($rose(irq_reg));

    // Outputs straight from flip-flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign music_serial_out = sout_reg;
    assign irq = irq_reg;
endmodule

/* verif/muart_instr.sv */
`timescale 1ns/10ps
module muart_instr #(
    parameter int BIT_CYCLES = 8
)
(
    // Clock
    input wire logic pclk,
    // Serial lines
    input wire logic music_serial_out,
    output logic music_serial_in
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    logic [9:0] fr;

    // Line idles high, as with a pull-up
    initial music_serial_in = 1'h1;

    task automatic send(input logic [7:0] b);
        fr = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++)
        begin
            music_serial_in <= fr[i];
            repeat (BIT_CYCLES) @(posedge pclk);
        end
    endtask

    initial
    begin
        forever
        begin
            @(negedge music_serial_out);
            repeat (BIT_CYCLES / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYCLES) @(posedge pclk);
                sh[i] = music_serial_out;
            end
            repeat (BIT_CYCLES) @(posedge pclk);
            if (music_serial_out === 1'h1)
                rx_q.push_back(sh);
        end
    end
endmodule

/* verif/test_midi_uart_mode_port.sv */
`include "muart_consts.svh"
`timescale 1ns/10ps
module test_midi_uart_mode_port;
    localparam int BC = 8;
    localparam logic [11:0] A_DAT = `MUART_IDX_DATA << 2;
    localparam logic [11:0] A_CMD = `MUART_IDX_CMD << 2;
    localparam logic [11:0] A_IST = `MUART_IDX_ISTAT << 2;
    localparam logic [11:0] A_ICL = `MUART_IDX_ICLR << 2;
    localparam logic [11:0] A_IEN = `MUART_IDX_IEN << 2;
    localparam logic [11:0] A_CFG = `MUART_IDX_CFG << 2;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic pready, pslverr, ser_in, ser_out, irq, se;
    int err_count = 0;
    int cmp_count = 0;
    int trig[4] = '{`MUART_TRIG0, `MUART_TRIG1, `MUART_TRIG2, `MUART_TRIG3};

    // 20 MHz clock
    always #25 pclk = ~pclk;

    muart_port #(.BIT_CYCLES(BC)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .music_serial_in(ser_in),
        .music_serial_out(ser_out), .irq(irq));
    muart_instr #(.BIT_CYCLES(BC)) peer (.pclk(pclk), .music_serial_out(ser_out),
        .music_serial_in(ser_in));

    // One APB transfer, held until pready, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rv = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chkb(input string nm, input logic exp, input logic got);
        chk(nm, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'h0, a, 8'h00);
        chk(nm, exp, rv);
    endtask

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cuts a hang short
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chkb("irq idle", 1'h0, irq);
        rdc(A_DAT, 32'hFE, "idle data");
        rdc(A_CMD, 32'h3F, "idle status");
        apb(1'h0, 12'h020, 8'h00);
        chkb("unmapped error", 1'h1, se);
        apb(1'h1, A_CMD, `MUART_CMD_UART);
        // Trigger code 0 means one byte, so the ack byte also raises the level bit
        rdc(A_IST, 32'h3, "ack flag and level");
        rdc(A_CMD, 32'h3F, "status waiting");
        rdc(A_DAT, 32'hFE, "ack byte");
        rdc(A_CMD, 32'hBF, "status empty");
        apb(1'h1, A_ICL, 8'h02);
        rdc(A_IST, 32'h0, "ack cleared");
        apb(1'h1, A_IEN, 8'h01);
        // Every trigger code: fill to the level, mask, drain
        for (int k = 0; k < 4; k++)
        begin
            apb(1'h1, A_CFG, 8'(k << 1));
            for (int i = 0; i < trig[k]; i++)
            begin
                chkb("irq below level", 1'h0, irq);
                peer.send(8'h10 + 8'(i));
                repeat (4) @(posedge pclk);
            end
            chkb("irq at level", 1'h1, irq);
            apb(1'h1, A_IEN, 8'h00);
            // Mask lands at the access edge, irq follows one edge later
            @(posedge pclk);
            chkb("irq masked", 1'h0, irq);
            apb(1'h1, A_IEN, 8'h01);
            for (int i = 0; i < trig[k]; i++)
            begin
                rdc(A_DAT, 32'h10 + 32'(i), "rx byte");
                repeat (2) @(posedge pclk);
                chkb("irq after pop", 1'h0, irq);
            end
        end
        // Two frames in first-in order
        apb(1'h1, A_DAT, 8'h5A);
        apb(1'h1, A_DAT, 8'hC3);
        repeat (25 * BC) @(posedge pclk);
        chk("tx first", 32'h5A, peer.rx_q.pop_front());
        chk("tx second", 32'hC3, peer.rx_q.pop_front());
        // Fill the transmit FIFO to full, then a no-op and a reset mid-frame
        for (int i = 0; i < 17; i++)
            apb(1'h1, A_DAT, 8'hA0 + 8'(i));
        rdc(A_CMD, 32'hFF, "status tx full");
        apb(1'h1, A_CMD, 8'h55);
        rdc(A_CMD, 32'hFF, "status after no-op");
        apb(1'h1, A_CMD, `MUART_CMD_RESET);
        rdc(A_CMD, 32'h3F, "status after reset");
        rdc(A_DAT, 32'hFE, "data after reset");
        repeat (30 * BC) @(posedge pclk);
        chk("frames after reset", 32'h1, peer.rx_q.size());
        chk("frame in flight", 32'hA0, peer.rx_q.pop_front());
        end_of_test();
    end
endmodule
